//--- inc/mlsx_defs.vh
// Constants for the load/shift/subtract/return execution block
// Notes on behaviour
// RULE1 - Load copies immediate or source register into destination; flags untouched.
// RULE2 - OR writes destination OR operand; zero from result, carry cleared.
// RULE3 - Output drives port_select with port number or source, data with destination.
// RULE4 - Return loads PC with stack top plus one and pops; flags untouched.
// RULE5 - Conditional returns act only on carry set/clear or zero clear/set.
// RULE6 - Interrupt return loads stack top, restores flags, sets enable per variant.
// RULE7 - Rotate left: bit 7 wraps to bit 0 and carry; zero from result.
// RULE8 - Rotate right: bit 0 wraps to bit 7 and carry; zero from result.
// RULE9 - Shift left zero fill: bit 7 to carry; zero from result.
// RULE10 - Shift left one fill: bit 7 to carry; zero flag always cleared.
// RULE11 - Shift left through carry: old carry enters bit 0, bit 7 to carry.
// RULE12 - Shift left replicate: bit 0 kept, bit 7 to carry, zero from result.
// RULE13 - Shift right zero fill: bit 0 to carry; zero from result.
// RULE14 - Shift right one fill: bit 0 to carry; zero flag always cleared.
// RULE15 - Shift right through carry: old carry enters bit 7, bit 0 to carry.
// RULE16 - Arithmetic shift right keeps bit 7; bit 0 to carry; zero from result.
// RULE17 - Store writes destination to scratchpad at immediate or source address.
// RULE18 - Subtract: destination minus operand; zero from result, carry is borrow.
// RULE19 - Subtract with borrow also subtracts carry; both flags updated.
// RULE20 - Interrupt saves flags, pushes PC, clears interrupt enable.
// RULE21 - Destination and source each select one of sixteen 8-bit registers.
// RULE22 - Scratchpad immediate addresses are 6 bits; port numbers are 8 bits.
// RULE23 - Output gives a one-cycle write strobe while port and data are valid.
// RULE24 - Failed conditional return advances PC and leaves the stack alone.
// RULE25 - Port logic latches output data only while the write strobe is high.
`ifndef MLSX_DEFS_VH
`define MLSX_DEFS_VH
`define MLSX_OFS_EXEC    12'h000
`define MLSX_OFS_STATUS  12'h004
`define MLSX_OFS_PC      12'h008
`define MLSX_OFS_IRQ     12'h00C
`define MLSX_OFS_STKTOP  12'h010
`define MLSX_GPR_BASE    6'h01
`define MLSX_SPAD_BASE   4'h1
`define MLSX_OPC_LSB     0
`define MLSX_OPC_MSB     4
`define MLSX_DST_LSB     8
`define MLSX_SRC_LSB     12
`define MLSX_IMM_LSB     16
`define MLSX_USE_IMM_BIT 24
`define MLSX_ST_ZERO     0
`define MLSX_ST_CARRY    1
`define MLSX_ST_INT_EN   2
`define MLSX_ST_PZERO    3
`define MLSX_ST_PCARRY   4
`define MLSX_OP_LOAD     5'h00
`define MLSX_OP_OR       5'h01
`define MLSX_OP_OUTPUT   5'h02
`define MLSX_OP_RET      5'h03
`define MLSX_OP_RET_C    5'h04
`define MLSX_OP_RET_NC   5'h05
`define MLSX_OP_RET_NZ   5'h06
`define MLSX_OP_RET_Z    5'h07
`define MLSX_OP_IRET_DIS 5'h08
`define MLSX_OP_IRET_EN  5'h09
`define MLSX_OP_RL       5'h0A
`define MLSX_OP_RR       5'h0B
`define MLSX_OP_SL0      5'h0C
`define MLSX_OP_SL1      5'h0D
`define MLSX_OP_SLA      5'h0E
`define MLSX_OP_SLX      5'h0F
`define MLSX_OP_SR0      5'h10
`define MLSX_OP_SR1      5'h11
`define MLSX_OP_SRA      5'h12
`define MLSX_OP_SRX      5'h13
`define MLSX_OP_STORE    5'h14
`define MLSX_OP_SUB      5'h15
`define MLSX_OP_SUBTRACT_WITH_BORROW    5'h16
`define MLSX_IRQ_VECTOR  10'h3FF
`define MLSX_STACK_DEPTH 5'h1F
`define MLSX_PC_RESET    10'h000
`endif

//--- rtl/mlsx_core.v
// Execution unit for loads, OR, output, returns, shifts, stores and subtraction
`timescale 1ns/10ps
`include "mlsx_defs.vh"
module mlsx_core
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [7:0]  port_select,
    output reg  [7:0]  out_data,
    output reg         write_strobe
);
    reg  [7:0]  gpr [0:15];
    reg  [7:0]  spad [0:63];
    reg  [9:0]  stack [0:30];
    reg  [4:0]  sp;
    reg  [9:0]  pc;
    reg         zero;
    reg         carry;
    reg         pzero;
    reg         pcarry;
    reg         int_enable;
    reg  [31:0] last_instr;
    reg         dp_write;
    reg         dp_read;
    reg  [11:0] dp_addr;
    integer     i;

    wire [4:0]  opc      = hwdata[`MLSX_OPC_MSB:`MLSX_OPC_LSB];
    wire [3:0]  dst      = hwdata[`MLSX_DST_LSB+3:`MLSX_DST_LSB];
    wire [3:0]  src      = hwdata[`MLSX_SRC_LSB+3:`MLSX_SRC_LSB];
    wire [7:0]  imm      = hwdata[`MLSX_IMM_LSB+7:`MLSX_IMM_LSB];
    wire        use_imm  = hwdata[`MLSX_USE_IMM_BIT];
    wire [7:0]  dv       = gpr[dst];
    wire [7:0]  opnd     = use_imm ? imm : gpr[src];
    // Pointer wraps over the 31 entries, so a deep overflow overwrites the oldest return
    wire [4:0]  sp_dec   = (sp == 5'h00) ? (`MLSX_STACK_DEPTH - 5'h01) : (sp - 5'h01);
    wire [4:0]  sp_inc   = (sp == `MLSX_STACK_DEPTH - 5'h01) ? 5'h00 : (sp + 5'h01);
    wire [9:0]  stack_top      = stack[sp_dec];
    wire        addr_ok  = hsel & hready & htrans[1];
    // Data-phase decodes; only word offsets are compared
    wire        hit_exec   = (dp_addr == `MLSX_OFS_EXEC);
    wire        hit_status = (dp_addr == `MLSX_OFS_STATUS);
    wire        hit_pc     = (dp_addr == `MLSX_OFS_PC);
    wire        hit_stktop = (dp_addr == `MLSX_OFS_STKTOP);
    wire        hit_gpr    = (dp_addr[11:6] == `MLSX_GPR_BASE);
    wire        hit_spad   = (dp_addr[11:8] == `MLSX_SPAD_BASE);
    wire        exec_wr    = dp_write & hit_exec;
    // Read and write share one bit layout, so software can save and restore the flags
    wire [31:0] status_word = {22'h000000, sp, pcarry, pzero, int_enable, carry, zero};

    reg  [7:0]  next_val;
    reg         next_zero;
    reg         next_carry;
    reg         wr_dst;
    reg         wr_flags;
    reg         do_ret;
    reg         do_iret;
    reg  [8:0]  diff;
    reg  [31:0] next_hrdata;

    // Decode and compute one instruction from the word being written
    always @*
    begin
        next_val   = dv;
        next_carry = carry;
        wr_dst     = 1'b0;
        wr_flags   = 1'b0;
        do_ret     = 1'b0;
        do_iret    = 1'b0;
        diff       = 9'h000;
        case (opc)
            `MLSX_OP_LOAD:
            begin
                next_val = opnd; // RULE1
                wr_dst   = 1'b1;
            end
            `MLSX_OP_OR:
            begin
                next_val   = dv | opnd; // RULE2
                next_carry = 1'b0;
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_RET:     do_ret = 1'b1; // RULE4
            `MLSX_OP_RET_C:   do_ret = carry; // RULE5
            `MLSX_OP_RET_NC:  do_ret = ~carry; // RULE5
            `MLSX_OP_RET_NZ:  do_ret = ~zero; // RULE5
            `MLSX_OP_RET_Z:   do_ret = zero; // RULE5
            `MLSX_OP_IRET_DIS,
            `MLSX_OP_IRET_EN: do_iret = 1'b1; // RULE6
            `MLSX_OP_RL:
            begin
                next_val   = {dv[6:0], dv[7]}; // RULE7
                next_carry = dv[7];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_RR:
            begin
                next_val   = {dv[0], dv[7:1]}; // RULE8
                next_carry = dv[0];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SL0:
            begin
                next_val   = {dv[6:0], 1'b0}; // RULE9
                next_carry = dv[7];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SL1:
            begin
                next_val   = {dv[6:0], 1'b1}; // RULE10
                next_carry = dv[7];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SLA:
            begin
                next_val   = {dv[6:0], carry}; // RULE11
                next_carry = dv[7];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SLX:
            begin
                next_val   = {dv[6:0], dv[0]}; // RULE12
                next_carry = dv[7];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SR0:
            begin
                next_val   = {1'b0, dv[7:1]}; // RULE13
                next_carry = dv[0];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SR1:
            begin
                next_val   = {1'b1, dv[7:1]}; // RULE14
                next_carry = dv[0];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SRA:
            begin
                next_val   = {carry, dv[7:1]}; // RULE15
                next_carry = dv[0];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SRX:
            begin
                next_val   = {dv[7], dv[7:1]}; // RULE16
                next_carry = dv[0];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SUB:
            begin
                diff       = {1'b0, dv} - {1'b0, opnd}; // RULE18
                next_val   = diff[7:0];
                next_carry = diff[8];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_SUBTRACT_WITH_BORROW:
            begin
                diff       = {1'b0, dv} - {1'b0, opnd} - {8'h00, carry}; // RULE19
                next_val   = diff[7:0];
                next_carry = diff[8];
                wr_dst     = 1'b1;
                wr_flags   = 1'b1;
            end
            `MLSX_OP_OUTPUT,
            `MLSX_OP_STORE:
            begin
                // Destination is only read; port and scratchpad are written at the edge
                next_val = dv;
            end
            default:
            begin
                next_val = dv;
            end
        endcase
        // One-fill shifts can never give zero, so the test is exact for them too
        next_zero = (next_val == 8'h00); // RULE10 RULE14
    end

    // Read multiplexer; unmapped offsets and the write-only interrupt request read as zero
    always @*
    begin
        next_hrdata = 32'h00000000;
        if (hit_exec)
            next_hrdata = last_instr;
        else if (hit_status)
            next_hrdata = status_word;
        else if (hit_pc)
            next_hrdata = {22'h000000, pc};
        else if (hit_stktop)
            next_hrdata = {22'h000000, stack_top};
        else if (hit_gpr)
            next_hrdata = {24'h000000, gpr[dp_addr[5:2]]};
        else if (hit_spad)
            next_hrdata = {24'h000000, spad[dp_addr[7:2]]};
    end

    // AHB-Lite slave: writes finish with no wait, reads take one wait state
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write  <= 1'b0;
            dp_read   <= 1'b0;
            dp_addr   <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end
        else
        begin
            hresp <= 1'b0;
            if (dp_read)
            begin
                // Read mux sees state after any write ended at the previous edge
                hrdata    <= next_hrdata;
                hreadyout <= 1'b1;
                dp_read   <= 1'b0;
                dp_write  <= 1'b0;
            end
            else
            begin
                dp_write  <= addr_ok & hwrite;
                dp_read   <= addr_ok & ~hwrite;
                hreadyout <= ~(addr_ok & ~hwrite);
                if (addr_ok)
                    dp_addr <= {haddr[11:2], 2'b00};
            end
        end
    end

    // Architectural state: executes the written instruction at the data phase edge
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (i = 0; i < 16; i = i + 1)
                gpr[i] <= 8'h00;
            for (i = 0; i < 64; i = i + 1)
                spad[i] <= 8'h00;
            for (i = 0; i < 31; i = i + 1)
                stack[i] <= 10'h000;
            sp           <= 5'd0;
            pc           <= `MLSX_PC_RESET;
            zero         <= 1'b0;
            carry        <= 1'b0;
            pzero        <= 1'b0;
            pcarry       <= 1'b0;
            int_enable   <= 1'b0;
            last_instr   <= 32'h00000000;
        end
        else
        begin
            if (exec_wr)
            begin
                last_instr <= hwdata;
                if (wr_dst)
                    gpr[dst] <= next_val; // RULE21
                if (wr_flags)
                begin
                    zero  <= next_zero;
                    carry <= next_carry;
                end
                if (opc == `MLSX_OP_STORE)
                    spad[opnd[5:0]] <= dv; // RULE17 RULE22
                if (do_ret)
                begin
                    pc <= stack_top + 10'h001; // RULE4
                    sp <= sp_dec;
                end
                else if (do_iret)
                begin
                    pc         <= stack_top; // RULE6
                    sp         <= sp_dec;
                    zero       <= pzero;
                    carry      <= pcarry;
                    int_enable <= (opc == `MLSX_OP_IRET_EN);
                end
                else
                    pc <= pc + 10'h001; // RULE24
            end
            else if (dp_write && dp_addr == `MLSX_OFS_IRQ && hwdata[0])
            begin
                // Interrupt event: only taken while enabled
                if (int_enable)
                begin
                    pzero      <= zero; // RULE20
                    pcarry     <= carry;
                    stack[sp]  <= pc;
                    sp         <= sp_inc;
                    pc         <= `MLSX_IRQ_VECTOR;
                    int_enable <= 1'b0;
                end
            end
            else if (dp_write && hit_status)
            begin
                zero       <= hwdata[`MLSX_ST_ZERO];
                carry      <= hwdata[`MLSX_ST_CARRY];
                pzero      <= hwdata[`MLSX_ST_PZERO];
                pcarry     <= hwdata[`MLSX_ST_PCARRY];
                int_enable <= hwdata[`MLSX_ST_INT_EN];
            end
            else if (dp_write && dp_addr == `MLSX_OFS_PC)
                pc <= hwdata[9:0];
            else if (dp_write && dp_addr[11:6] == `MLSX_GPR_BASE)
                gpr[dp_addr[5:2]] <= hwdata[7:0];
            else if (dp_write && dp_addr[11:8] == `MLSX_SPAD_BASE)
                spad[dp_addr[7:2]] <= hwdata[7:0];
        end
    end

    // Output port registers; port number and data hold until the next output
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            port_select  <= 8'h00;
            out_data     <= 8'h00;
            write_strobe <= 1'b0;
        end
        else
        begin
            write_strobe <= 1'b0;
            if (exec_wr && opc == `MLSX_OP_OUTPUT)
            begin
                port_select  <= opnd; // RULE3 RULE22
                out_data     <= dv;
                write_strobe <= 1'b1; // RULE23
            end
        end
    end
endmodule

//--- sim/mlsx_port_sink.sv
// Far-side port decoder model that captures output bytes under the write strobe
`timescale 1ns/10ps
module mlsx_port_sink
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire [7:0]  port_select,
    input  wire [7:0]  out_data,
    input  wire        write_strobe,
    output reg  [7:0]  seen_port,
    output reg  [7:0]  seen_data,
    output reg  [31:0] seen_count
);
    // Latching outside the strobe would pick up held values and hide a missing pulse
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            seen_port  <= 8'h00;
            seen_data  <= 8'h00;
            seen_count <= 32'h0;
        end
        else if (write_strobe)
        begin
            seen_port  <= port_select;
            seen_data  <= out_data;
            seen_count <= seen_count + 32'h1;
        end
    end
endmodule

//--- sim/mlsx_core_sva.sv
// Port assertions for the execution block, bound to its top module
`timescale 1ns/10ps
`include "mlsx_defs.vh"
module mlsx_core_sva
(
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [7:0]  port_select,
    input wire [7:0]  out_data,
    input wire        write_strobe
);
    wire addr_phase = hsel && hready && htrans[1];
    wire exec_write = addr_phase && hwrite && (haddr[11:2] == 10'h000);
    wire out_op     = (hwdata[4:0] == `MLSX_OP_OUTPUT);
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_resp_okay; hresp == 1'b0; endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("slave response not OKAY");
    property p_strobe_single; write_strobe |=> !write_strobe; endproperty
    a_strobe_single: assert property (p_strobe_single) else $error("strobe longer than one cycle");
    property p_strobe_after; exec_write ##1 out_op |=> write_strobe; endproperty
    a_strobe_after: assert property (p_strobe_after) else $error("no strobe after output");
    property p_strobe_cause; write_strobe |-> $past(out_op) && $past(exec_write, 2); endproperty
    a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without output");
    property p_port_imm; exec_write ##1 (out_op && hwdata[24]) |=> port_select == $past(hwdata[23:16]); endproperty
    a_port_imm: assert property (p_port_imm) else $error("port number not driven");
    property p_port_hold; !write_strobe |-> $stable(port_select) && $stable(out_data); endproperty
    a_port_hold: assert property (p_port_hold) else $error("port buses moved without strobe");
    property p_read_wait; addr_phase && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    property p_write_nowait; addr_phase && hwrite |=> hreadyout; endproperty
    a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
endmodule
bind mlsx_core mlsx_core_sva chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .port_select(port_select), .out_data(out_data), .write_strobe(write_strobe));

//--- sim/mcu_load_shift_sub_return_exec_bench.sv
// Self-checking bench for the load, shift, subtract and return execution block
`timescale 1ns/10ps
`include "mlsx_defs.vh"
module mcu_load_shift_sub_return_exec_bench;
    reg         hclk, hresetn, hsel, hwrite;
    reg  [31:0] haddr, hwdata, w, rd;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    wire [31:0] hrdata, seen_count;
    wire        hreadyout, hresp, write_strobe;
    wire [7:0]  port_select, out_data, seen_port, seen_data;
    reg  [7:0]  g [0:15];
    reg  [7:0]  ram [0:63];
    reg  [9:0]  stk [0:30];
    reg  [9:0]  pc;
    reg  [7:0]  x, y, r;
    reg         z, c, ie, pz, pcy;
    integer     sp, nout, i, k, n_fail, checks_done;
    mlsx_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port_select(port_select), .out_data(out_data),
        .write_strobe(write_strobe));
    mlsx_port_sink far_end (.hclk(hclk), .hresetn(hresetn), .port_select(port_select),
        .out_data(out_data), .write_strobe(write_strobe), .seen_port(seen_port),
        .seen_data(seen_data), .seen_count(seen_count));
    function [31:0] stat();
        stat = {22'h0, sp[4:0], pcy, pz, ie, c, z};
    endfunction
    task ahb(input [31:0] a, input wr, input [31:0] d);
    begin
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
    end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
        checks_done = checks_done + 1;
        if (s !== e)
        begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, s);
        end
    end
    endtask
    task rdchk(input string nm, input [31:0] a, input [31:0] e);
    begin
        ahb(a, 1'b0, 32'h0);
        chk(nm, e, rd);
    end
    endtask
    task print_verdict;
    begin
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    // Flags and registers change in place, so operands x and y are captured before the call
    task model_exec;
        reg [4:0] op;
        reg       ret;
        reg       iret;
    begin
        op = w[4:0];
        r = x;
        ret = 1'b0;
        iret = (op == `MLSX_OP_IRET_DIS) || (op == `MLSX_OP_IRET_EN);
        pc = pc + 10'd1;
        case (op)
            `MLSX_OP_LOAD:   r = y;
            `MLSX_OP_OR:     {c, r} = {1'b0, x | y};
            `MLSX_OP_RET:    ret = 1'b1;
            `MLSX_OP_RET_C:  ret = c;
            `MLSX_OP_RET_NC: ret = !c;
            `MLSX_OP_RET_NZ: ret = !z;
            `MLSX_OP_RET_Z:  ret = z;
            `MLSX_OP_IRET_DIS, `MLSX_OP_IRET_EN: {z, c, ie} = {pz, pcy, op[0]};
            `MLSX_OP_RL:     {c, r} = {x[7], x[6:0], x[7]};
            `MLSX_OP_RR:     {c, r} = {x[0], x[0], x[7:1]};
            `MLSX_OP_SL0:    {c, r} = {x[7], x[6:0], 1'b0};
            `MLSX_OP_SL1:    {c, r} = {x[7], x[6:0], 1'b1};
            `MLSX_OP_SLA:    {c, r} = {x[7], x[6:0], c};
            `MLSX_OP_SLX:    {c, r} = {x[7], x[6:0], x[0]};
            `MLSX_OP_SR0:    {c, r} = {x[0], 1'b0, x[7:1]};
            `MLSX_OP_SR1:    {c, r} = {x[0], 1'b1, x[7:1]};
            `MLSX_OP_SRA:    {c, r} = {x[0], c, x[7:1]};
            `MLSX_OP_SRX:    {c, r} = {x[0], x[7], x[7:1]};
            `MLSX_OP_STORE:  ram[y[5:0]] = x;
            `MLSX_OP_SUB:    {c, r} = {1'b0, x} - {1'b0, y};
            `MLSX_OP_SUBTRACT_WITH_BORROW:  {c, r} = {1'b0, x} - {1'b0, y} - c;
            default:         r = x;
        endcase
        if (ret)
            pc = stk[(sp + 30) % 31] + 10'd1;
        if (iret)
            pc = stk[(sp + 30) % 31];
        if (ret || iret)
            sp = (sp + 30) % 31;
        // Codes above the last subtract are no-ops and leave both flags alone
        if (op == `MLSX_OP_OR || (op >= `MLSX_OP_RL && op <= `MLSX_OP_SRX) ||
            op == `MLSX_OP_SUB || op == `MLSX_OP_SUBTRACT_WITH_BORROW)
            z = (r == 8'h00);
        g[w[11:8]] = r;
    end
    endtask
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial
    begin
        repeat (60000) @(posedge hclk);
        n_fail = n_fail + 1;
        print_verdict;
    end
    initial
    begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata, hsize} = {37'h0, 32'h0, 3'b010};
        {z, c, ie, pz, pcy, pc} = 15'h0;
        sp = 0;
        nout = 0;
        n_fail = 0;
        checks_done = 0;
        for (k = 0; k < 64; k = k + 1)
        begin
            ram[k] = 8'h00;
            g[k % 16] = 8'h00;
            stk[k % 31] = 10'h000;
        end
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        w = $urandom(32'h90e2);
        rdchk("status", `MLSX_OFS_STATUS, stat());
        for (k = 0; k < 16; k = k + 1)
        begin
            rdchk("gpr", 32'h40 + 4 * k, 32'h0);
            w = $urandom;
            g[k] = w[7:0];
            ahb(32'h40 + 4 * k, 1'b1, {24'h0, g[k]});
        end
        ahb(32'h800, 1'b1, 32'hFFFF_FFFF);
        rdchk("unmapped", 32'h800, 32'h0);
        for (i = 0; i < 240; i = i + 1)
        begin
            if (i % 12 == 0)
            begin
                w = $urandom;
                {pcy, pz, ie, c, z} = w[4:0];
                pc = w[14:5];
                ahb(`MLSX_OFS_STATUS, 1'b1, w & 32'h1F);
                ahb(`MLSX_OFS_PC, 1'b1, {22'h0, pc});
            end
            if (i % 5 == 0)
            begin
                ahb(`MLSX_OFS_IRQ, 1'b1, 32'h1);
                if (ie)
                begin
                    {stk[sp], pz, pcy, ie, pc} = {pc, z, c, 1'b0, 10'h3FF};
                    sp = (sp + 1) % 31;
                end
            end
            w = ($urandom & 32'h01FF_FF00) | $urandom_range(23, 0);
            x = g[w[11:8]];
            y = w[24] ? w[23:16] : g[w[15:12]];
            ahb(`MLSX_OFS_EXEC, 1'b1, w);
            model_exec;
            rdchk("status", `MLSX_OFS_STATUS, stat());
            rdchk("pc", `MLSX_OFS_PC, {22'h0, pc});
            rdchk("dest", 32'h40 + 4 * w[11:8], {24'h0, g[w[11:8]]});
            rdchk("stack top", `MLSX_OFS_STKTOP, {22'h0, stk[(sp + 30) % 31]});
            if (w[4:0] == `MLSX_OP_STORE)
                rdchk("scratch", 32'h100 + 4 * y[5:0], {24'h0, x});
            if (w[4:0] == `MLSX_OP_OUTPUT)
            begin
                nout = nout + 1;
                chk("port", {24'h0, y}, {24'h0, seen_port});
                chk("data", {24'h0, x}, {24'h0, seen_data});
                chk("count", nout, seen_count);
            end
        end
        print_verdict;
    end
endmodule
